// [core/hbm_pkg.sv]
package hbm_pkg;

	// Register byte addresses on the AXI4-Lite slave.
	localparam logic [3:0] CTRL_ADDR   = 4'h0;
	localparam logic [3:0] STATUS_ADDR = 4'h4;

	// Control register fields and reset value.
	localparam int         CTRL_OUT_ON_BIT = 0;
	localparam logic       CTRL_OUT_ON_RST = 1'h1;

	// Status register field positions.
	localparam int         STAT_OUT_LSB  = 0;
	localparam int         STAT_IN_LSB   = 4;
	localparam int         STAT_MODE_BIT = 8;
	localparam int         STAT_ON_BIT   = 9;

	// Bus response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Mode select levels.
	localparam logic       MODE_DUAL_INPUT = 1'h0;
	localparam logic       MODE_PHASE_EN   = 1'h1;

	// Bridge count and reset level of the bridge outputs.
	localparam int         BRIDGES     = 2;
	localparam logic [3:0] OUT_RST     = 4'h0;

endpackage : hbm_pkg

// [core/hbm_dual_bridge.sv]
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module hbm_dual_bridge (
	// Clock and synchronous active-low reset.
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Register bus, write side.
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [3:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// Register bus, read side.
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [3:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// Mode select and the four bridge control levels.
	input  wire logic        phase_enable_mode,
	input  wire logic        bridge_a_ctrl_first,
	input  wire logic        bridge_a_ctrl_second,
	input  wire logic        bridge_b_ctrl_first,
	input  wire logic        bridge_b_ctrl_second,
	// Registered bridge output levels toward the motor terminals.
	output logic             bridge_a_output_first,
	output logic             bridge_a_output_second,
	output logic             bridge_b_output_first,
	output logic             bridge_b_output_second
);

	// The block has two parts that share one state register.
	// The first part turns the mode select and the four control levels into
	// the four bridge output levels, one clock after the pins are sampled.
	// The second part is a small register bus slave with a control word and
	// a status word.
	// The control word carries one switch that can force every output low,
	// which lets software park the motors without touching the pins.
	// The status word reflects the pins, the mode and the registered outputs,
	// so software can see exactly what the bridges are being told to do.
	// Write address and write data may arrive in either order; the write is
	// carried out only once both halves are held.
	// Only one write and one read can be under way at a time, which keeps
	// the slave small and makes the response order trivial.
	// Outputs come from flip-flops, so a glitch on a control pin between
	// clock edges never reaches the motor terminals.

	// All state of the block, registered as one word.
	typedef struct packed {
		// Output switch and the registered bridge levels.
		logic        out_on;
		logic [3:0]  drive;

		// Write address half, held until the write is done.
		logic        aw_got;
		logic [3:0]  aw_addr;

		// Write data half, held until the write is done.
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;

		// Write response, standing until the master takes it.
		logic        bvalid;
		logic [1:0]  bresp;

		// Read response, standing until the master takes it.
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} hbm_state_s;

	hbm_state_s st_reg;
	hbm_state_s st_next;

	// Control pins gathered into one vector.
	logic [3:0] ctrl_in;
	// Decoded output levels before the output switch and register.
	logic [3:0] bridge_drive;
	// Status word as it would be read in the present cycle.
	logic [31:0] status_word;

	// Pack the control pins as {B second, B first, A second, A first}.
	assign ctrl_in = {bridge_b_ctrl_second, bridge_b_ctrl_first,
		bridge_a_ctrl_second, bridge_a_ctrl_first};

	// Per-bridge output decode; bridge 0 is A, bridge 1 is B.
	// Each bridge sees only its own pair of pins, so the two DC motors stay
	// independent in phase/enable mode.
	// In dual-input mode the four levels pass straight through for a stepper.
	for (genvar g = 0; g < hbm_pkg::BRIDGES; g++) begin : g_bridge
		logic in_first;
		logic in_second;
		assign in_first  = ctrl_in[2 * g];
		assign in_second = ctrl_in[2 * g + 1];
		always_comb begin
			if (phase_enable_mode == hbm_pkg::MODE_PHASE_EN) begin
				// Enable gates the bridge; phase picks which side goes high.
				if (in_second) begin
					bridge_drive[2 * g]     = ~in_first;
					bridge_drive[2 * g + 1] = in_first;
				end else begin
					bridge_drive[2 * g]     = 1'b0;
					bridge_drive[2 * g + 1] = 1'b0;
				end
			end else begin
				bridge_drive[2 * g]     = in_first;
				bridge_drive[2 * g + 1] = in_second;
			end
		end
	end

	// Status word shows outputs, pin levels, mode and the output switch.
	always_comb begin
		status_word = '0;
		status_word[hbm_pkg::STAT_OUT_LSB +: 4] = st_reg.drive;
		status_word[hbm_pkg::STAT_IN_LSB +: 4]  = ctrl_in;
		status_word[hbm_pkg::STAT_MODE_BIT]     = phase_enable_mode;
		status_word[hbm_pkg::STAT_ON_BIT]       = st_reg.out_on;
	end

	// Next-state logic for the bus slave and the output drive.
	always_comb begin
		st_next = st_reg;
		// The output switch in the control register forces all outputs low.
		st_next.drive = st_reg.out_on ? bridge_drive : hbm_pkg::OUT_RST;
		// Capture write address and data independently, in either order.
		if (awvalid && awready) begin
			st_next.aw_got  = 1'b1;
			st_next.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			st_next.w_got  = 1'b1;
			st_next.w_data = wdata;
			st_next.w_strb = wstrb;
		end

		// Perform the write once both halves are held.
		// Both halves stay refused while the response stands, so a second
		// write cannot overtake the first.
		if (st_reg.aw_got && st_reg.w_got) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			if (st_reg.aw_addr == hbm_pkg::CTRL_ADDR) begin
				st_next.bresp = hbm_pkg::RESP_OKAY;
				if (st_reg.w_strb[0]) begin
					st_next.out_on = st_reg.w_data[hbm_pkg::CTRL_OUT_ON_BIT];
				end
			end else if (st_reg.aw_addr == hbm_pkg::STATUS_ADDR) begin
				st_next.bresp = hbm_pkg::RESP_OKAY; // Read-only; write ignored.
			end else begin
				st_next.bresp = hbm_pkg::RESP_SLVERR;
			end
		end

		// The write response drops at the edge where the master takes it.
		if (st_reg.bvalid && bready) begin
			st_next.bvalid = 1'b0;
		end

		// Reads answer at the same edge that takes the address.
		// The address is refused while a read response stands.
		if (arvalid && arready) begin
			st_next.rvalid = 1'b1;
			st_next.rresp  = hbm_pkg::RESP_OKAY;
			st_next.rdata  = '0;
			if (araddr == hbm_pkg::CTRL_ADDR) begin
				st_next.rdata[hbm_pkg::CTRL_OUT_ON_BIT] = st_reg.out_on;
			end else if (araddr == hbm_pkg::STATUS_ADDR) begin
				st_next.rdata = status_word;
			end else begin
				st_next.rresp = hbm_pkg::RESP_SLVERR;
			end
		end else if (st_reg.rvalid && rready) begin
			st_next.rvalid = 1'b0;
		end
	end

	// State register with synchronous active-low reset.
	// Reset leaves the outputs low and the output switch on, so the bridges
	// follow the pins as soon as reset is released.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg        <= '0;
			st_reg.out_on <= hbm_pkg::CTRL_OUT_ON_RST;
			st_reg.drive  <= hbm_pkg::OUT_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	// Ready outputs are combinational; valid, response and data outputs come from flip-flops.
	assign awready = !st_reg.aw_got && !st_reg.bvalid;
	assign wready  = !st_reg.w_got && !st_reg.bvalid;
	assign bvalid  = st_reg.bvalid;
	assign bresp   = st_reg.bresp;
	assign arready = !st_reg.rvalid;
	assign rvalid  = st_reg.rvalid;
	assign rdata   = st_reg.rdata;
	assign rresp   = st_reg.rresp;

	// Registered bridge levels, bit order {B2, B1, A2, A1}.
	assign bridge_a_output_first  = st_reg.drive[0];
	assign bridge_a_output_second = st_reg.drive[1];
	assign bridge_b_output_first  = st_reg.drive[2];
	assign bridge_b_output_second = st_reg.drive[3];

endmodule : hbm_dual_bridge

// [verification/hbm_sva.sv]
`timescale 1ns/1ps
module hbm_sva (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic phase_enable_mode,
	input wire logic bridge_a_ctrl_first,
	input wire logic bridge_a_ctrl_second,
	input wire logic bridge_b_ctrl_first,
	input wire logic bridge_b_ctrl_second,
	input wire logic bridge_a_output_first,
	input wire logic bridge_a_output_second,
	input wire logic bridge_b_output_first,
	input wire logic bridge_b_output_second
);
	// Pins and outputs gathered as {A1, A2, B1, B2}.
	wire logic [3:0] i = {bridge_a_ctrl_first, bridge_a_ctrl_second,
		bridge_b_ctrl_first, bridge_b_ctrl_second};
	wire logic [3:0] o = {bridge_a_output_first, bridge_a_output_second,
		bridge_b_output_first, bridge_b_output_second};
	wire logic m = phase_enable_mode;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_dual; $past(aresetn && !m) |-> o == $past(i); endproperty
	a_dual: assert property (p_dual) else $error("dual output wrong");
	property p_aoff; $past(aresetn && m && !i[2]) |-> o[3:2] == 2'h0; endproperty
	a_aoff: assert property (p_aoff) else $error("bridge A not off");
	property p_boff; $past(aresetn && m && !i[0]) |-> o[1:0] == 2'h0; endproperty
	a_boff: assert property (p_boff) else $error("bridge B not off");
	property p_adir; $past(aresetn && m && i[2]) |-> o[3:2] == {!$past(i[3]), $past(i[3])};
	endproperty
	a_adir: assert property (p_adir) else $error("bridge A direction");
	property p_bdir; $past(aresetn && m && i[0]) |-> o[1:0] == {!$past(i[1]), $past(i[1])};
	endproperty
	a_bdir: assert property (p_bdir) else $error("bridge B direction");
	property p_excl; $past(aresetn && m) |-> o[3:2] != 2'h3 && o[1:0] != 2'h3; endproperty
	a_excl: assert property (p_excl) else $error("bridge both high");
	property p_hold; $past(aresetn) && $stable(i) && $stable(m) |=> $stable(o); endproperty
	a_hold: assert property (p_hold) else $error("output moved");
	c_fwd: cover property (m && i[2] && !i[3]);
	c_rev: cover property (m && i[0] && i[1]);
	c_step: cover property (!m && i == 4'hC);
endmodule : hbm_sva
bind hbm_dual_bridge hbm_sva u_sva (.*);

// [verification/hbm_ctrl_model.sv]
`timescale 1ns/1ps
module hbm_ctrl_model (
	input wire logic aclk,
	output logic mode,
	output logic [3:0] pins
);
	// Mode and bridge inputs {A1, A2, B1, B2} stay low until the first command.
	initial {mode, pins} = 5'h00;
	// Sets a level pattern; an enable pulse train is a run of these.
	task set(input logic m, input logic [3:0] p);
		@(posedge aclk);
		mode <= m;
		pins <= p;
	endtask : set
	// Rotates the stepper pattern one place.
	task step(input logic left);
		@(posedge aclk);
		pins <= left ? {pins[2:0], pins[3]} : {pins[0], pins[3:1]};
	endtask : step
endmodule : hbm_ctrl_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD %0t %h %h", $time, (a), (b)); end end
module tb_top;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, e;
	logic [31:0] d = 32'h0, q;
	logic [1:0] r;
	wire awready, wready, bvalid, arready, rvalid, mode;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [3:0] p, o;
	int error_cnt = 0, comparisons = 0;
	// Clock at 40 MHz.
	always #12.5 aclk = ~aclk;
	hbm_ctrl_model ctl (.aclk(aclk), .mode(mode), .pins(p));
	hbm_dual_bridge dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(d), .wstrb(4'hF),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
		.araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.phase_enable_mode(mode), .bridge_a_ctrl_first(p[3]), .bridge_a_ctrl_second(p[2]),
		.bridge_b_ctrl_first(p[1]), .bridge_b_ctrl_second(p[0]), .bridge_a_output_first(o[3]),
		.bridge_a_output_second(o[2]), .bridge_b_output_first(o[1]),
		.bridge_b_output_second(o[0]));
	// Expected outputs {A1, A2, B1, B2} for a mode and pin pattern.
	function automatic logic [3:0] dec(input logic m, input logic [3:0] v);
		return m ? {~v[3] & v[2], v[3] & v[2], ~v[1] & v[0], v[1] & v[0]} : v;
	endfunction : dec
	// Checks the outputs once the next edge has landed.
	task exp(input logic [3:0] x);
		@(posedge aclk);
		#1 `CHK(o, x)
	endtask : exp
	// Bus read; levels seen mid-cycle are the ones the next rising edge takes.
	task rd(input logic [3:0] a);
		@(posedge aclk);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		q = rdata;
		r = rresp;
		@(posedge aclk);
		rready <= 0;
	endtask : rd
	// Bus write; each half is released at the edge that takes it.
	task wr(input logic [3:0] a, input logic [31:0] v);
		logic aw_on;
		logic w_on;
		@(posedge aclk);
		{awvalid, wvalid, bready} <= 3'h7;
		awaddr <= a;
		d <= v;
		aw_on = 1'b1;
		w_on = 1'b1;
		while (aw_on || w_on) begin
			@(negedge aclk);
			if (awready === 1'b1) aw_on = 1'b0;
			if (wready === 1'b1) w_on = 1'b0;
			@(posedge aclk);
			awvalid <= aw_on;
			wvalid <= w_on;
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		@(posedge aclk);
		bready <= 0;
	endtask : wr
	// Every pin pattern in both modes, then stepping three left and five right.
	task t_decode;
		for (int m = 0; m < 2; m++) for (int v = 0; v < 16; v++) begin
			ctl.set(m[0], v[3:0]);
			exp(dec(m[0], v[3:0]));
		end
		ctl.set(hbm_pkg::MODE_DUAL_INPUT, 4'hC);
		e = 4'hC;
		exp(e);
		for (int s = 0; s < 8; s++) begin
			ctl.step(s < 3);
			e = s < 3 ? {e[2:0], e[3]} : {e[0], e[3:1]};
			exp(e);
		end
		// Enable pulse train on both bridges with phase held low.
		for (int k = 0; k < 6; k++) begin
			ctl.set(hbm_pkg::MODE_PHASE_EN, k[0] ? 4'h5 : 4'h0);
			exp(k[0] ? 4'hA : 4'h0);
		end
	endtask : t_decode
	// Control write, status readback and an unmapped read.
	task t_regs;
		rd(hbm_pkg::CTRL_ADDR);
		`CHK(q, 32'h0000_0001)
		ctl.set(hbm_pkg::MODE_PHASE_EN, 4'h6);
		wr(hbm_pkg::CTRL_ADDR, 32'h0000_0001);
		`CHK(r, hbm_pkg::RESP_OKAY)
		rd(hbm_pkg::STATUS_ADDR);
		`CHK(q, 32'h0000_0361)
		rd(4'h8);
		`CHK(r, hbm_pkg::RESP_SLVERR)
	endtask : t_regs
	// Prints the counts and the verdict.
	task stop_test;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// Main sequence after four reset cycles.
	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		exp(4'h0);
		t_regs;
		t_decode;
		stop_test;
	end
	// Watchdog, far beyond the hundred or so cycles the run needs.
	initial begin
		#50us;
		error_cnt++;
		stop_test;
	end
endmodule : tb_top
